// >>> hw/timer8_compare_output.sv
// Functional notes
// - output mode picks flop action on match
// - reset clears output-state flop to zero
// - nonzero output mode overrides port latch
// - pin shows value only when direction output
// - override independent of waveform mode
// - flop presettable while override disabled
// - output mode zero leaves flop unchanged
// - new output mode acts at next match
// - force strobe applies action at once in non-pwm modes
// - waveform mode alone sets counting sequence
// - pwm: polarity; non-pwm: set/clear/toggle
// - normal mode counts up, wraps ff to 00
// - overflow flag set as count becomes zero
// - count writable anytime in normal mode
// - clear-on-match clears count after match
// - compare flag set at top, may request
// - compare value writes act immediately
// - compare below count waits for wrap
// - output mode one toggles on match
// - compare zero toggles every timer clock
// - match sets compare flag, ack or w1c
// - force leaves flag and counter alone
// - count write blocks next-cycle match
// - count write beats clear or count
//
// Design decisions made here: strobed register access and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none

module timer8_compare_output #(
  parameter int PRESCALE = timer8_pkg::PRESCALE_DIV
) (
  input wire logic clk,
  input wire logic nrst,
  input wire timer8_pkg::regbus_req_s busReq,
  output logic [timer8_pkg::DATA_W-1:0] rdata,
  input wire logic portLatch,
  input wire logic dirBit,
  input wire logic ovfAck,
  input wire logic cmpAck,
  output logic ovfIrq,
  output logic cmpIrq,
  output timer8_pkg::pin_s pin
);

  localparam int DIV_W = $clog2(PRESCALE);
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(PRESCALE - 1);

  if (PRESCALE < 2) begin : g_bad_prescale
    $error("prescale must be at least 2");
  end

  logic [1:0] rstPipe;
  logic rstN;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rstPipe <= 2'h0;
    end else begin
      rstPipe <= {rstPipe[0], 1'b1};
    end
  end
  assign rstN = rstPipe[1];

  timer8_pkg::waveform_mode_e wave, next_wave;
  timer8_pkg::compare_output_mode_e com, next_com;
  timer8_pkg::clock_source_select_e clkSel, next_clkSel;
  logic [7:0] count, next_count;
  logic [7:0] compare, next_compare;
  logic [DIV_W-1:0] divCnt, next_divCnt;
  logic ovfFlag, next_ovfFlag;
  logic cmpFlag, next_cmpFlag;
  logic ovfEn, next_ovfEn;
  logic cmpEn, next_cmpEn;
  logic outState, next_outState;
  logic blockPend, next_blockPend;
  logic [7:0] next_rdata;

  logic tick;
  logic pwm;
  logic match;
  logic matchEv;
  logic wrapEv;
  logic ctrlWr;
  logic countWr;
  logic flagsWr;
  logic stateWr;
  logic forceEv;
  timer8_pkg::compare_output_mode_e wrCom;
  timer8_pkg::waveform_mode_e wrWave;

  function automatic logic apply(input logic s,
                                 input timer8_pkg::compare_output_mode_e m);
    logic r;
    r = s;
    unique case (m)
      timer8_pkg::OUT_NONE: r = s;
      timer8_pkg::OUT_TOGGLE: r = ~s;
      timer8_pkg::OUT_CLEAR: r = 1'b0;
      timer8_pkg::OUT_SET: r = 1'b1;
    endcase
    return r;
  endfunction : apply

  always_comb begin
    ctrlWr = busReq.wr && (busReq.addr == timer8_pkg::REG_CTRL);
    countWr = busReq.wr && (busReq.addr == timer8_pkg::REG_COUNT);
    flagsWr = busReq.wr && (busReq.addr == timer8_pkg::REG_FLAGS);
    stateWr = busReq.wr && (busReq.addr == timer8_pkg::REG_STATE);
    wrCom = timer8_pkg::compare_output_mode_e'(
      busReq.wdata[timer8_pkg::CTRL_COM_LSB +: 2]);
    wrWave = timer8_pkg::waveform_mode_e'(
      busReq.wdata[timer8_pkg::CTRL_WAVE_LSB +: 2]);
    unique case (clkSel)
      timer8_pkg::CLK_DIV1: tick = 1'b1;
      timer8_pkg::CLK_DIVN: tick = (divCnt == DIV_LAST);
      default: tick = 1'b0;
    endcase
    pwm = wave[0];
    match = (count == compare) && !blockPend;
    matchEv = tick && match;
    wrapEv = tick && !countWr && (count == timer8_pkg::COUNT_MAX);
    forceEv = ctrlWr && busReq.wdata[timer8_pkg::CTRL_FORCE_BIT] && !wrWave[0];
  end

  // counter, prescaler and flags
  always_comb begin
    next_divCnt = (divCnt == DIV_LAST) ? '0 : divCnt + 1'b1;
    next_count = count;
    if (countWr) begin
      next_count = busReq.wdata;
    end else if (tick) begin
      if (wave == timer8_pkg::WAVE_CLEAR_ON_MATCH && match) begin
        next_count = timer8_pkg::COUNT_BOTTOM;
      end else begin
        next_count = count + 8'h01;
      end
    end
    if (countWr) begin
      next_blockPend = 1'b1;
    end else if (tick) begin
      next_blockPend = 1'b0;
    end else begin
      next_blockPend = blockPend;
    end
    next_ovfFlag = wrapEv |
      (ovfFlag & ~(ovfAck | (flagsWr && busReq.wdata[timer8_pkg::FLAG_OVF_BIT])));
    next_cmpFlag = matchEv |
      (cmpFlag & ~(cmpAck | (flagsWr && busReq.wdata[timer8_pkg::FLAG_CMP_BIT])));
  end

  // output-state flop
  always_comb begin
    next_outState = outState;
    if (stateWr) begin
      next_outState = busReq.wdata[timer8_pkg::STATE_BIT];
    end else if (forceEv) begin
      next_outState = apply(outState, wrCom);
    end else if (matchEv) begin
      if (!pwm) begin
        next_outState = apply(outState, com);
      end else if (com == timer8_pkg::OUT_CLEAR || com == timer8_pkg::OUT_SET) begin
        next_outState = apply(outState, com);
      end
    end else if (pwm && wrapEv) begin
      if (com == timer8_pkg::OUT_CLEAR) begin
        next_outState = 1'b1;
      end else if (com == timer8_pkg::OUT_SET) begin
        next_outState = 1'b0;
      end
    end
  end

  // register writes and reads
  always_comb begin
    next_wave = wave;
    next_com = com;
    next_clkSel = clkSel;
    next_compare = compare;
    next_ovfEn = ovfEn;
    next_cmpEn = cmpEn;
    if (ctrlWr) begin
      next_wave = wrWave;
      next_com = wrCom;
    end
    if (busReq.wr && busReq.addr == timer8_pkg::REG_CLKSEL) begin
      next_clkSel = timer8_pkg::clock_source_select_e'(
        busReq.wdata[timer8_pkg::CLKSEL_LSB +: 3]);
    end
    if (busReq.wr && busReq.addr == timer8_pkg::REG_COMPARE) begin
      next_compare = busReq.wdata;
    end
    if (busReq.wr && busReq.addr == timer8_pkg::REG_INTEN) begin
      next_ovfEn = busReq.wdata[timer8_pkg::INTEN_OVF_BIT];
      next_cmpEn = busReq.wdata[timer8_pkg::INTEN_CMP_BIT];
    end
    next_rdata = timer8_pkg::BYTE_RESET;
    if (busReq.rd) begin
      unique case (busReq.addr)
        timer8_pkg::REG_CTRL: begin
          next_rdata[timer8_pkg::CTRL_WAVE_LSB +: 2] = wave;
          next_rdata[timer8_pkg::CTRL_COM_LSB +: 2] = com;
        end
        timer8_pkg::REG_CLKSEL: next_rdata[timer8_pkg::CLKSEL_LSB +: 3] = clkSel;
        timer8_pkg::REG_COUNT: next_rdata = count;
        timer8_pkg::REG_COMPARE: next_rdata = compare;
        timer8_pkg::REG_FLAGS: begin
          next_rdata[timer8_pkg::FLAG_OVF_BIT] = ovfFlag;
          next_rdata[timer8_pkg::FLAG_CMP_BIT] = cmpFlag;
          next_rdata[timer8_pkg::FLAG_STATE_BIT] = outState;
        end
        timer8_pkg::REG_INTEN: begin
          next_rdata[timer8_pkg::INTEN_OVF_BIT] = ovfEn;
          next_rdata[timer8_pkg::INTEN_CMP_BIT] = cmpEn;
        end
        timer8_pkg::REG_STATE: next_rdata[timer8_pkg::STATE_BIT] = outState;
        default: next_rdata = timer8_pkg::BYTE_RESET;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      wave <= timer8_pkg::WAVE_NORMAL;
      com <= timer8_pkg::OUT_NONE;
      clkSel <= timer8_pkg::CLK_STOP;
      count <= timer8_pkg::BYTE_RESET;
      compare <= timer8_pkg::BYTE_RESET;
      divCnt <= '0;
      ovfFlag <= 1'b0;
      cmpFlag <= 1'b0;
      ovfEn <= 1'b0;
      cmpEn <= 1'b0;
      outState <= 1'b0;
      blockPend <= 1'b0;
      rdata <= timer8_pkg::BYTE_RESET;
    end else begin
      wave <= next_wave;
      com <= next_com;
      clkSel <= next_clkSel;
      count <= next_count;
      compare <= next_compare;
      divCnt <= next_divCnt;
      ovfFlag <= next_ovfFlag;
      cmpFlag <= next_cmpFlag;
      ovfEn <= next_ovfEn;
      cmpEn <= next_cmpEn;
      outState <= next_outState;
      blockPend <= next_blockPend;
      rdata <= next_rdata;
    end
  end

  // pin source and direction
  always_comb begin
    pin.out = (com != timer8_pkg::OUT_NONE) ? outState : portLatch;
    pin.oeN = ~dirBit;
    ovfIrq = ovfFlag & ovfEn;
    cmpIrq = cmpFlag & cmpEn;
  end

  // checks
  chk_reset_state_low: assert property (@(posedge clk)
    $rose(rstN) |-> !outState)
    else $error("output state not zero after reset");

  chk_pin_override_src: assert property (@(posedge clk) disable iff (!rstN)
    (com != timer8_pkg::OUT_NONE) && (outState != portLatch) |-> pin.out == outState)
    else $error("override does not drive output state");

  chk_pin_dir_gate: assert property (@(posedge clk) disable iff (!rstN)
    !dirBit |-> pin.oeN)
    else $error("pin driven while direction is input");

  chk_none_keeps_state: assert property (@(posedge clk) disable iff (!rstN)
    com == timer8_pkg::OUT_NONE && !ctrlWr && !stateWr |=> $stable(outState))
    else $error("mode none changed output state");

  chk_ctc_toggle_match: assert property (@(posedge clk) disable iff (!rstN)
    wave == timer8_pkg::WAVE_CLEAR_ON_MATCH && com == timer8_pkg::OUT_TOGGLE
    && matchEv && !busReq.wr |=> outState != $past(outState))
    else $error("toggle missing on match");

  chk_normal_wrap_ovf: assert property (@(posedge clk) disable iff (!rstN)
    wave == timer8_pkg::WAVE_NORMAL && wrapEv |=> count == 8'h00 && ovfFlag)
    else $error("normal wrap or overflow wrong");

  chk_ctc_clear_top: assert property (@(posedge clk) disable iff (!rstN)
    wave == timer8_pkg::WAVE_CLEAR_ON_MATCH && matchEv && !countWr |=> count == 8'h00)
    else $error("counter not cleared on match");

  chk_match_sets_flag: assert property (@(posedge clk) disable iff (!rstN)
    matchEv |=> cmpFlag)
    else $error("compare flag not set");

  chk_force_no_flag: assert property (@(posedge clk) disable iff (!rstN)
    forceEv && !matchEv && !cmpFlag && !countWr && !tick |=> !cmpFlag && $stable(count))
    else $error("force touched flag or counter");

  chk_write_blocks_match: assert property (@(posedge clk) disable iff (!rstN)
    blockPend && tick && !cmpFlag |=> !cmpFlag)
    else $error("match after count write not blocked");

  chk_write_beats_count: assert property (@(posedge clk) disable iff (!rstN)
    countWr |=> count == $past(busReq.wdata))
    else $error("count write lost");

  chk_ovf_write_clear: assert property (@(posedge clk) disable iff (!rstN)
    flagsWr && busReq.wdata[timer8_pkg::FLAG_OVF_BIT] && !wrapEv |=> !ovfFlag)
    else $error("overflow flag not cleared");

  chk_clear_on_match: assert property (@(posedge clk) disable iff (!rstN)
    !pwm && matchEv && com == timer8_pkg::OUT_CLEAR && !busReq.wr |=> !outState)
    else $error("clear action missing on match");

  chk_set_on_match: assert property (@(posedge clk) disable iff (!rstN)
    !pwm && matchEv && com == timer8_pkg::OUT_SET && !busReq.wr |=> outState)
    else $error("set action missing on match");

  chk_force_set_state: assert property (@(posedge clk) disable iff (!rstN)
    forceEv && wrCom == timer8_pkg::OUT_SET |=> outState)
    else $error("forced set not applied");

  chk_force_toggle_state: assert property (@(posedge clk) disable iff (!rstN)
    forceEv && wrCom == timer8_pkg::OUT_TOGGLE |=> outState != $past(outState))
    else $error("forced toggle not applied");

  chk_state_preset: assert property (@(posedge clk) disable iff (!rstN)
    stateWr && busReq.wdata[timer8_pkg::STATE_BIT] |=> outState)
    else $error("output state preset lost");

  chk_latch_when_none: assert property (@(posedge clk) disable iff (!rstN)
    com == timer8_pkg::OUT_NONE |-> pin.out == portLatch)
    else $error("port latch not on pin with mode none");

  chk_ovf_same_cycle: assert property (@(posedge clk) disable iff (!rstN)
    wrapEv |=> ovfFlag)
    else $error("overflow flag late on wrap");

  chk_ovf_ack_clear: assert property (@(posedge clk) disable iff (!rstN)
    ovfAck && !wrapEv |=> !ovfFlag)
    else $error("overflow flag not cleared by service");

  chk_cmp_ack_clear: assert property (@(posedge clk) disable iff (!rstN)
    cmpAck && !matchEv |=> !cmpFlag)
    else $error("compare flag not cleared by service");

  chk_cmp_write_clear: assert property (@(posedge clk) disable iff (!rstN)
    flagsWr && busReq.wdata[timer8_pkg::FLAG_CMP_BIT] && !matchEv |=> !cmpFlag)
    else $error("compare flag not cleared by write");

  chk_ovf_zero_keeps: assert property (@(posedge clk) disable iff (!rstN)
    ovfFlag && flagsWr && !busReq.wdata[timer8_pkg::FLAG_OVF_BIT] && !ovfAck |=> ovfFlag)
    else $error("overflow flag lost on zero write");

  chk_compare_write: assert property (@(posedge clk) disable iff (!rstN)
    busReq.wr && busReq.addr == timer8_pkg::REG_COMPARE |=> compare == $past(busReq.wdata))
    else $error("compare value write not immediate");

  chk_normal_count_up: assert property (@(posedge clk) disable iff (!rstN)
    wave == timer8_pkg::WAVE_NORMAL && tick && !countWr |=> count == $past(count) + 8'h01)
    else $error("normal mode count step wrong");

  cov_ctc_toggle: cover property (@(posedge clk) disable iff (!rstN)
    wave == timer8_pkg::WAVE_CLEAR_ON_MATCH && com == timer8_pkg::OUT_TOGGLE && matchEv);
  cov_normal_ovf: cover property (@(posedge clk) disable iff (!rstN)
    wave == timer8_pkg::WAVE_NORMAL && wrapEv);
  cov_force: cover property (@(posedge clk) disable iff (!rstN) forceEv);
  cov_block: cover property (@(posedge clk) disable iff (!rstN)
    blockPend && tick && count == compare);
  cov_prescale_tick: cover property (@(posedge clk) disable iff (!rstN)
    clkSel == timer8_pkg::CLK_DIVN && tick);

endmodule : timer8_compare_output

`default_nettype wire

// >>> hw/timer8_pkg.sv
package timer8_pkg;

  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;

  // register map
  localparam logic [ADDR_W-1:0] REG_CTRL = 3'h0;
  localparam logic [ADDR_W-1:0] REG_CLKSEL = 3'h1;
  localparam logic [ADDR_W-1:0] REG_COUNT = 3'h2;
  localparam logic [ADDR_W-1:0] REG_COMPARE = 3'h3;
  localparam logic [ADDR_W-1:0] REG_FLAGS = 3'h4;
  localparam logic [ADDR_W-1:0] REG_INTEN = 3'h5;
  localparam logic [ADDR_W-1:0] REG_STATE = 3'h6;

  // field positions
  localparam int CTRL_WAVE_LSB = 0;
  localparam int CTRL_COM_LSB = 4;
  localparam int CTRL_FORCE_BIT = 7;
  localparam int CLKSEL_LSB = 0;
  localparam int FLAG_OVF_BIT = 0;
  localparam int FLAG_CMP_BIT = 1;
  localparam int FLAG_STATE_BIT = 2;
  localparam int INTEN_OVF_BIT = 0;
  localparam int INTEN_CMP_BIT = 1;
  localparam int STATE_BIT = 0;

  // values
  localparam logic [DATA_W-1:0] COUNT_MAX = 8'hff;
  localparam logic [DATA_W-1:0] COUNT_BOTTOM = 8'h00;
  localparam logic [DATA_W-1:0] BYTE_RESET = 8'h00;
  localparam int PRESCALE_DIV = 8;

  typedef enum logic [1:0] {
    WAVE_NORMAL = 2'h0,
    WAVE_PWM_PHASE = 2'h1,
    WAVE_CLEAR_ON_MATCH = 2'h2,
    WAVE_PWM_FAST = 2'h3
  } waveform_mode_e;

  typedef enum logic [1:0] {
    OUT_NONE = 2'h0,
    OUT_TOGGLE = 2'h1,
    OUT_CLEAR = 2'h2,
    OUT_SET = 2'h3
  } compare_output_mode_e;

  typedef enum logic [2:0] {
    CLK_STOP = 3'h0,
    CLK_DIV1 = 3'h1,
    CLK_DIVN = 3'h2
  } clock_source_select_e;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } regbus_req_s;

  typedef struct packed {
    logic out;
    logic oeN;
  } pin_s;

endpackage : timer8_pkg

// >>> tb/port_pin_model.sv
`timescale 1ns/1ns
`default_nettype none

module port_pin_model (
  input wire logic clk,
  input wire logic wantLatch,
  input wire logic wantDir,
  input wire timer8_pkg::pin_s pin,
  output logic portLatch,
  output logic dirBit,
  output logic padLevel
);
  logic lastPad = 1'b0;
  assign portLatch = wantLatch;
  assign dirBit = wantDir;
  // undriven pad shows the inverse of the last driven level
  assign padLevel = !pin.oeN ? pin.out : !lastPad;
  always @(posedge clk) begin
    if (!pin.oeN)
      lastPad <= pin.out;
  end
endmodule : port_pin_model

`default_nettype wire

// >>> tb/timer8_compare_output_normal_ctc_tb_top.sv
`timescale 1ns/1ns
`default_nettype none

module timer8_compare_output_normal_ctc_tb_top;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  timer8_pkg::regbus_req_s busReq = '0;
  logic [7:0] rdata;
  logic wantLatch = 1'b0;
  logic wantDir = 1'b0;
  logic ovfAck = 1'b0;
  logic cmpAck = 1'b0;
  logic portLatch, dirBit, ovfIrq, cmpIrq, padLevel;
  timer8_pkg::pin_s pin;
  logic [7:0] v;
  logic s;
  int err_total = 0;
  int checks = 0;

  initial forever #25 clk = ~clk;

  timer8_compare_output #(.PRESCALE(2)) timer8_compare_output_i (.clk(clk), .nrst(nrst),
    .busReq(busReq), .rdata(rdata), .portLatch(portLatch), .dirBit(dirBit),
    .ovfAck(ovfAck), .cmpAck(cmpAck), .ovfIrq(ovfIrq), .cmpIrq(cmpIrq), .pin(pin));

  port_pin_model port_pin_model_i (.clk(clk), .wantLatch(wantLatch), .wantDir(wantDir),
    .pin(pin), .portLatch(portLatch), .dirBit(dirBit), .padLevel(padLevel));

  task automatic final_report();
    $display("checks=%0d err_total=%0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : final_report

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic chkBit(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chkBit

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    busReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    busReq.wr <= 1'b0;
    #1;
  endtask : wr

  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk);
    busReq <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    busReq.rd <= 1'b0;
    #1;
    d = rdata;
  endtask : rd

  task automatic setPort(input logic l, input logic d);
    @(posedge clk);
    wantLatch <= l;
    wantDir <= d;
    #1;
  endtask : setPort

  task automatic t_reset();
    rd(timer8_pkg::REG_STATE, v);
    chk(v, 8'h00);
    setPort(1'b1, 1'b1);
    chkBit(pin.out, 1'b1);
    chkBit(padLevel, 1'b1);
  endtask : t_reset

  task automatic t_preset();
    setPort(1'b0, 1'b1);
    wr(timer8_pkg::REG_STATE, 8'h01);
    chkBit(pin.out, 1'b0);
    wr(timer8_pkg::REG_CTRL, 8'h10);
    chkBit(pin.out, 1'b1);
    wr(timer8_pkg::REG_CTRL, 8'h12);
    chkBit(pin.out, 1'b1);
    setPort(1'b0, 1'b0);
    chkBit(pin.oeN, 1'b1);
    setPort(1'b0, 1'b1);
  endtask : t_preset

  task automatic t_force();
    logic [7:0] ctl [4] = '{8'ha0, 8'hb0, 8'h80, 8'h90};
    logic [7:0] want [4] = '{8'h00, 8'h01, 8'h01, 8'h00};
    for (int i = 0; i < 4; i++) begin
      wr(timer8_pkg::REG_CTRL, ctl[i]);
      rd(timer8_pkg::REG_STATE, v);
      chk(v, want[i]);
    end
    chkBit(pin.out, 1'b0);
    rd(timer8_pkg::REG_FLAGS, v);
    chk(v & 8'h03, 8'h00);
    rd(timer8_pkg::REG_COUNT, v);
    chk(v, 8'h00);
  endtask : t_force

  task automatic t_ctc();
    wr(timer8_pkg::REG_INTEN, 8'h02);
    wr(timer8_pkg::REG_CTRL, 8'h12);
    wr(timer8_pkg::REG_CLKSEL, 8'h01);
    for (int i = 0; i < 6; i++) begin
      s = pin.out;
      tick(1);
      chkBit(pin.out, !s);
    end
    wr(timer8_pkg::REG_CLKSEL, 8'h00);
    rd(timer8_pkg::REG_COUNT, v);
    chk(v, 8'h00);
    rd(timer8_pkg::REG_FLAGS, v);
    chk(v & 8'h03, 8'h02);
    chkBit(cmpIrq, 1'b1);
    wr(timer8_pkg::REG_FLAGS, 8'h00);
    chkBit(cmpIrq, 1'b1);
    wr(timer8_pkg::REG_FLAGS, 8'h02);
    chkBit(cmpIrq, 1'b0);
    wr(timer8_pkg::REG_CLKSEL, 8'h01);
    wr(timer8_pkg::REG_CLKSEL, 8'h00);
    chkBit(cmpIrq, 1'b1);
    @(posedge clk);
    cmpAck <= 1'b1;
    @(posedge clk);
    cmpAck <= 1'b0;
    tick(1);
    chkBit(cmpIrq, 1'b0);
  endtask : t_ctc

  task automatic t_ovf();
    wr(timer8_pkg::REG_CTRL, 8'h00);
    wr(timer8_pkg::REG_INTEN, 8'h01);
    wr(timer8_pkg::REG_COUNT, 8'hfe);
    wr(timer8_pkg::REG_CLKSEL, 8'h01);
    for (int i = 0; i < 10 && ovfIrq !== 1'b1; i++)
      tick(1);
    chkBit(ovfIrq, 1'b1);
    if (ovfIrq !== 1'b1)
      final_report();
    wr(timer8_pkg::REG_CLKSEL, 8'h00);
    rd(timer8_pkg::REG_COUNT, v);
    chk(v, 8'h02);
    wr(timer8_pkg::REG_FLAGS, 8'h00);
    chkBit(ovfIrq, 1'b1);
    wr(timer8_pkg::REG_FLAGS, 8'h01);
    chkBit(ovfIrq, 1'b0);
    wr(timer8_pkg::REG_COUNT, 8'hff);
    wr(timer8_pkg::REG_CLKSEL, 8'h01);
    wr(timer8_pkg::REG_CLKSEL, 8'h00);
    chkBit(ovfIrq, 1'b1);
    rd(timer8_pkg::REG_COUNT, v);
    chk(v, 8'h01);
    @(posedge clk);
    ovfAck <= 1'b1;
    @(posedge clk);
    ovfAck <= 1'b0;
    tick(1);
    chkBit(ovfIrq, 1'b0);
  endtask : t_ovf

  task automatic t_block();
    wr(timer8_pkg::REG_CTRL, 8'h02);
    wr(timer8_pkg::REG_FLAGS, 8'h03);
    wr(timer8_pkg::REG_COMPARE, 8'h20);
    wr(timer8_pkg::REG_COUNT, 8'h20);
    wr(timer8_pkg::REG_CLKSEL, 8'h01);
    wr(timer8_pkg::REG_COMPARE, 8'h10);
    wr(timer8_pkg::REG_CLKSEL, 8'h00);
    rd(timer8_pkg::REG_FLAGS, v);
    chk(v & 8'h02, 8'h00);
    rd(timer8_pkg::REG_COUNT, v);
    chk(v & 8'hf0, 8'h20);
  endtask : t_block

  // divide-by-two tick: ten enabled clocks give five counts
  task automatic t_prescale();
    wr(timer8_pkg::REG_CTRL, 8'h30);
    wr(timer8_pkg::REG_STATE, 8'h00);
    wr(timer8_pkg::REG_COMPARE, 8'h03);
    wr(timer8_pkg::REG_COUNT, 8'h00);
    wr(timer8_pkg::REG_CLKSEL, 8'h02);
    tick(8);
    wr(timer8_pkg::REG_CLKSEL, 8'h00);
    rd(timer8_pkg::REG_COUNT, v);
    chk(v, 8'h05);
    rd(timer8_pkg::REG_FLAGS, v);
    chk(v & 8'h06, 8'h06);
    chkBit(pin.out, 1'b1);
  endtask : t_prescale

  initial begin
    #200000;
    err_total++;
    final_report();
  end

  initial begin
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    t_reset();
    t_preset();
    t_force();
    t_ctc();
    t_ovf();
    t_block();
    t_prescale();
    final_report();
  end
endmodule : timer8_compare_output_normal_ctc_tb_top

`default_nettype wire
